// file: verilog/npi_unit.sv
// nested priority interrupt unit, master mode, with apb register port
// Behaviour
// - a pending source requests the processor only while its mask bit is clear
// - its priority must be strictly above the priority mask level
// - its own in-service bit blocks it, unless special fully nested applies
// - its priority must be at least that of every in-service source
// - levels 0 highest to 7 lowest; priority mask resets to 7
// - acknowledge returns winner type, clears its request, sets its in-service
// - end-of-interrupt clears in-service; remaining pending sources re-evaluated
// - a timer event sets its status bit and the shared timer request
// - timer acknowledge serves lowest set status bit; shared request clears when none left
// - timer 0 beats timer 1, which beats timer 2
// - while timer in service, no timer request until end-of-interrupt
// - in cascade, pins 2 and 3 become acknowledge outputs for sources 0 and 1
// - acknowledge pins are inputs after reset until configured
// - special fully nested lets ext sources 0/1 preempt themselves
// - timer types are 8, 18 and 19, passed internally
// - dma types 10 and 11; external pins 12 to 15
// - in cascade the slave controller supplies the type
// - poll read returns and acknowledges winner; poll status only returns it
// - edge mode requests on rising edge, re-armed once pin is low
// - level mode requests while pin is high, recurring
// - unit adds 5 clocks latency; cascade adds 13 clocks response
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "npi_consts.svh"
module npi_unit
  import npi_pkg::*;
(
  input wire logic core_clk, // 250 MHz core clock
  input wire logic rst_n, // async reset
  input wire logic [11:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [2:0] tmr_evt, // timer event pulses
  input wire logic [1:0] dma_evt, // dma event pulses
  input wire logic ext_irq0_i, // external pin 0
  input wire logic ext_irq1_i, // external pin 1
  input wire logic ext_irq2_i, // pin 2 input
  output logic ext_irq2_o, // ack_out0, low active
  output logic ext_irq2_oe, // pin 2 drive enable
  input wire logic ext_irq3_i, // pin 3 input
  output logic ext_irq3_o, // ack_out1, low active
  output logic ext_irq3_oe, // pin 3 drive enable
  input wire logic cpu_ack, // processor acknowledge pulse
  input wire logic [7:0] slv_type, // type from slave controller
  output logic irq_req, // maskable request
  output npi_ans_s cpu_ans, // type answer
  output logic ext_ack_cyc // external acknowledge cycles run
);

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  npi_ctl_s [6:0] ctl_reg;
  logic [2:0] primask_reg;
  logic [6:0] req_reg;
  logic [6:0] isr_reg;
  logic [2:0] tstat_reg;
  logic [3:0] pin_s1_reg;
  logic [3:0] pin_s2_reg;
  logic [3:0] pin_prev_reg;
  npi_state_e state_reg;
  logic [3:0] cnt_reg;
  logic [3:0] lat_reg;
  logic ack0_n_reg;
  logic ack1_n_reg;
  logic win_vld;
  logic [2:0] win_idx;
  logic [1:0] tsel;
  logic [2:0] tstat_rest;
  logic [7:0] win_type;
  logic [3:0] ext_set;
  logic [6:0] src_set;
  logic [6:0] req_next;
  logic [6:0] isr_next;
  logic [2:0] tstat_next;
  logic [7:0] ix;
  logic done;
  logic wr;
  logic cpu_take;
  logic poll_take;
  logic take;
  logic win_casc;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [2:0] eoi_idx;
  logic eoi_do;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [1:0] first_tmr(input logic [2:0] s);
    if (s[0]) begin
      first_tmr = 2'h0;
    end else if (s[1]) begin
      first_tmr = 2'h1;
    end else begin
      first_tmr = 2'h2;
    end
  endfunction : first_tmr

  function automatic logic [7:0] src_type(input logic [2:0] i, input logic [1:0] t);
    case (i)
      3'h0: src_type = (t == 2'h0) ? `NPI_TYPE_T0 :
                       (t == 2'h1) ? `NPI_TYPE_T1 : `NPI_TYPE_T2;
      3'h1: src_type = `NPI_TYPE_DMA0;
      3'h2: src_type = `NPI_TYPE_DMA1;
      3'h3: src_type = `NPI_TYPE_EXT0;
      3'h4: src_type = `NPI_TYPE_EXT1;
      3'h5: src_type = `NPI_TYPE_EXT2;
      3'h6: src_type = `NPI_TYPE_EXT3;
      default: src_type = `NPI_TYPE_NONE;
    endcase
  endfunction : src_type

  // writable control bits per source
  function automatic logic [6:0] ctl_wmask(input int i);
    if (i == 3 || i == 4) begin
      ctl_wmask = 7'h7F;
    end else if (i >= 5) begin
      ctl_wmask = 7'h1F;
    end else begin
      ctl_wmask = 7'h0F;
    end
  endfunction : ctl_wmask

  // ------------------------------------------------------------
  // resolution
  // ------------------------------------------------------------
  npi_resolver u_res (
    .req(req_reg),
    .isr(isr_reg),
    .ctl(ctl_reg),
    .primask(primask_reg),
    .win_vld(win_vld),
    .win_idx(win_idx)
  );

  assign tsel = first_tmr(tstat_reg);
  assign tstat_rest = tstat_reg & ~(3'h1 << tsel);
  assign win_type = win_vld ? src_type(win_idx, tsel) : `NPI_TYPE_NONE;
  assign win_casc = (win_idx == 3'h3 && ctl_reg[3].cas) ||
                    (win_idx == 3'h4 && ctl_reg[4].cas);

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  assign ix = paddr[9:2];
  assign done = psel && penable && pready;
  assign wr = done && pwrite && !pslverr;
  assign cpu_take = cpu_ack && (state_reg == NPI_ST_IDLE) && win_vld;
  assign poll_take = done && !pwrite && (ix == `NPI_IX_POLL) && win_vld &&
                     !cpu_take;
  assign take = cpu_take || poll_take;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    case (ix)
      `NPI_IX_EOI: rd_data = 32'h0000_0000;
      `NPI_IX_POLL, `NPI_IX_PSTAT: begin
        rd_data[`NPI_POLL_VLD] = win_vld;
        rd_data[7:0] = win_type;
      end
      `NPI_IX_IMASK: begin
        for (int i = 0; i < 7; i++) begin
          rd_data[i] = ctl_reg[i].msk;
        end
      end
      `NPI_IX_PRIMASK: rd_data[2:0] = primask_reg;
      `NPI_IX_ISR: rd_data[6:0] = isr_reg;
      `NPI_IX_REQ: rd_data[6:0] = req_reg;
      `NPI_IX_TSTAT: rd_data[2:0] = tstat_reg;
      default: begin
        if (ix >= `NPI_IX_CTL_LO && ix <= `NPI_IX_CTL_HI && !ix[0]) begin
          rd_data[6:0] = ctl_reg[3'((ix - `NPI_IX_CTL_LO) >> 1)];
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  // one wait state; write and poll side effects at the completing edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      prdata <= rd_data;
      pslverr <= !rd_hit;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // configuration
  // ------------------------------------------------------------
  // reset levels follow the default source order
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 7; i++) begin
        ctl_reg[i] <= '{sfnm: 1'b0, cas: 1'b0, lvl: 1'b0,
                        msk: `NPI_MSK_RST, pm: 3'(i)};
      end
      primask_reg <= `NPI_PRIMASK_RST;
    end else if (wr) begin
      if (ix == `NPI_IX_PRIMASK) begin
        primask_reg <= pwdata[2:0];
      end
      for (int i = 0; i < 7; i++) begin
        if (ix == 8'(`NPI_IX_CTL_LO + 2 * i)) begin
          ctl_reg[i] <= npi_ctl_s'(pwdata[6:0] & ctl_wmask(i));
        end
        if (ix == `NPI_IX_IMASK) begin
          ctl_reg[i].msk <= pwdata[i];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // external pins
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
      pin_prev_reg <= 4'h0;
    end else begin
      pin_s1_reg <= {ext_irq3_i, ext_irq2_i, ext_irq1_i, ext_irq0_i};
      pin_s2_reg <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
    end
  end

  generate
    for (genvar g = 0; g < 4; g++) begin : g_pin
      logic pin_live;
      // pin 2 stops being an input while ext source 0 cascades, pin 3 while ext source 1 does
      if (g >= 2) begin : g_dual
        assign pin_live = pin_s2_reg[g] && !ctl_reg[g + 1].cas;
      end else begin : g_plain
        assign pin_live = pin_s2_reg[g];
      end
      assign ext_set[g] = ctl_reg[g + 3].lvl ? pin_live :
                          (pin_live && !pin_prev_reg[g]);
    end
  endgenerate

  assign src_set = {ext_set, dma_evt, |tmr_evt};

  // ------------------------------------------------------------
  // request, status and in-service state; set beats clear
  // ------------------------------------------------------------
  always_comb begin
    req_next = req_reg;
    isr_next = isr_reg;
    tstat_next = tstat_reg;
    // clear first so an acknowledge in the same cycle keeps its in-service bit
    if (eoi_do) begin
      isr_next[eoi_idx] = 1'b0;
    end
    if (take) begin
      isr_next[win_idx] = 1'b1;
      if (win_idx == 3'h0) begin
        tstat_next = tstat_rest;
        req_next[0] = |tstat_rest;
      end else begin
        req_next[win_idx] = 1'b0;
      end
    end
    req_next = req_next | src_set;
    tstat_next = tstat_next | tmr_evt;
  end

  // end-of-interrupt: specific by index, or highest in service
  always_comb begin
    eoi_do = wr && (ix == `NPI_IX_EOI);
    eoi_idx = pwdata[2:0];
    if (pwdata[`NPI_EOI_NSPEC]) begin
      eoi_idx = 3'h7;
      for (int i = 6; i >= 0; i--) begin
        if (isr_reg[i] && (eoi_idx == 3'h7 ||
            ctl_reg[i].pm <= ctl_reg[eoi_idx].pm)) begin
          eoi_idx = 3'(i);
        end
      end
    end
    if (eoi_idx == 3'h7) begin
      eoi_do = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_reg <= 7'h00;
      isr_reg <= 7'h00;
      tstat_reg <= 3'h0;
    end else begin
      req_reg <= req_next;
      isr_reg <= isr_next;
      tstat_reg <= tstat_next;
    end
  end

  // ------------------------------------------------------------
  // processor request with fixed added latency
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req <= 1'b0;
      lat_reg <= 4'h0;
    end else if (!win_vld || take || state_reg != NPI_ST_IDLE) begin
      irq_req <= 1'b0;
      lat_reg <= 4'h0;
    end else if (lat_reg == `NPI_ICU_LAT - 4'h1) begin
      irq_req <= 1'b1;
    end else begin
      lat_reg <= lat_reg + 4'h1;
    end
  end

  // ------------------------------------------------------------
  // acknowledge sequencing
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= NPI_ST_IDLE;
      cnt_reg <= 4'h0;
      cpu_ans <= '{vld: 1'b0, typ: `NPI_TYPE_NONE};
      ack0_n_reg <= 1'b1;
      ack1_n_reg <= 1'b1;
      ext_ack_cyc <= 1'b0;
    end else begin
      cpu_ans.vld <= 1'b0;
      case (state_reg)
        NPI_ST_IDLE: begin
          if (cpu_ack && win_vld && win_casc) begin
            state_reg <= NPI_ST_CASC;
            cnt_reg <= `NPI_CAS_LAT - 4'h1;
            ack0_n_reg <= (win_idx != 3'h3);
            ack1_n_reg <= (win_idx != 3'h4);
            ext_ack_cyc <= 1'b1;
          end else if (cpu_ack) begin
            cpu_ans <= '{vld: 1'b1, typ: win_type};
          end
        end
        NPI_ST_CASC: begin
          if (cnt_reg == 4'h0) begin
            state_reg <= NPI_ST_IDLE;
            cpu_ans <= '{vld: 1'b1, typ: slv_type};
            ack0_n_reg <= 1'b1;
            ack1_n_reg <= 1'b1;
            ext_ack_cyc <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        default: begin
          state_reg <= NPI_ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // dual-purpose pins
  // ------------------------------------------------------------
  // released pins idle high so a slave never sees a stray acknowledge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_irq2_oe <= 1'b0;
      ext_irq3_oe <= 1'b0;
      ext_irq2_o <= 1'b1;
      ext_irq3_o <= 1'b1;
    end else begin
      ext_irq2_oe <= ctl_reg[3].cas;
      ext_irq3_oe <= ctl_reg[4].cas;
      ext_irq2_o <= ack0_n_reg;
      ext_irq3_o <= ack1_n_reg;
    end
  end

endmodule : npi_unit

// file: verilog/npi_consts.svh
// constants of the nested priority interrupt unit
`ifndef NPI_CONSTS_SVH
`define NPI_CONSTS_SVH

// register indices; byte address is four times the index
`define NPI_IX_EOI 8'h22
`define NPI_IX_POLL 8'h24
`define NPI_IX_PSTAT 8'h26
`define NPI_IX_IMASK 8'h28
`define NPI_IX_PRIMASK 8'h2A
`define NPI_IX_ISR 8'h2C
`define NPI_IX_REQ 8'h2E
`define NPI_IX_TSTAT 8'h30
`define NPI_IX_CTL_LO 8'h32
`define NPI_IX_CTL_HI 8'h3E

// field positions
`define NPI_EOI_NSPEC 15
`define NPI_POLL_VLD 15

// reset values
`define NPI_MSK_RST 1'b1
`define NPI_PRIMASK_RST 3'h7

// fixed interrupt types
`define NPI_TYPE_T0 8'h08
`define NPI_TYPE_T1 8'h12
`define NPI_TYPE_T2 8'h13
`define NPI_TYPE_DMA0 8'h0A
`define NPI_TYPE_DMA1 8'h0B
`define NPI_TYPE_EXT0 8'h0C
`define NPI_TYPE_EXT1 8'h0D
`define NPI_TYPE_EXT2 8'h0E
`define NPI_TYPE_EXT3 8'h0F
`define NPI_TYPE_NONE 8'h00

// latencies in core clocks
`define NPI_ICU_LAT 4'h5
`define NPI_CAS_LAT 4'hD

`endif

// file: verilog/npi_pkg.sv
// types of the nested priority interrupt unit
package npi_pkg;

  // per-source control word
  typedef struct packed {
    logic sfnm;
    logic cas;
    logic lvl;
    logic msk;
    logic [2:0] pm;
  } npi_ctl_s;

  // answer to the processor
  typedef struct packed {
    logic vld;
    logic [7:0] typ;
  } npi_ans_s;

  typedef enum logic [1:0] {
    NPI_ST_IDLE = 2'b00,
    NPI_ST_CASC = 2'b01
  } npi_state_e;

endpackage : npi_pkg

// file: verilog/npi_resolver.sv
// priority resolution of pending sources
`timescale 1ns/1ns
module npi_resolver
  import npi_pkg::*;
(
  input wire logic [6:0] req, // pending request bits
  input wire logic [6:0] isr, // in-service bits
  input wire npi_ctl_s [6:0] ctl, // per-source control
  input wire logic [2:0] primask, // priority mask level
  output logic win_vld, // a source qualifies
  output logic [2:0] win_idx // winning source
);

  logic [3:0] isr_min;
  logic [3:0] best;

  // ------------------------------------------------------------
  // lowest level in service; 8 means none
  // ------------------------------------------------------------
  always_comb begin
    isr_min = 4'h8;
    for (int i = 0; i < 7; i++) begin
      if (isr[i] && ({1'b0, ctl[i].pm} < isr_min)) begin
        isr_min = {1'b0, ctl[i].pm};
      end
    end
  end

  // ------------------------------------------------------------
  // winner: strict compare keeps lower index on ties
  // ------------------------------------------------------------
  always_comb begin
    best = 4'h8;
    win_vld = 1'b0;
    win_idx = 3'h0;
    for (int i = 0; i < 7; i++) begin
      if (req[i] &&
          !ctl[i].msk &&
          (ctl[i].pm < primask) &&
          (!isr[i] || ctl[i].sfnm) &&
          ({1'b0, ctl[i].pm} <= isr_min) &&
          ({1'b0, ctl[i].pm} < best)) begin
        best = {1'b0, ctl[i].pm};
        win_vld = 1'b1;
        win_idx = i[2:0];
      end
    end
  end

endmodule : npi_resolver

// file: tb/npi_unit_sva.sv
// port checker for the nested priority interrupt unit
`timescale 1ns/1ns
module npi_unit_sva
  import npi_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic rst_n, // reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic cpu_ack, // acknowledge
  input wire logic irq_req, // request
  input wire npi_ans_s cpu_ans, // answer
  input wire logic ext_irq2_o, // ack_out0
  input wire logic ext_irq3_o, // ack_out1
  input wire logic ext_irq2_oe, // pin 2 enable
  input wire logic ext_irq3_oe, // pin 3 enable
  input wire logic ext_ack_cyc // cascade window
);
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire apb_wr = psel && penable && pwrite && pready;
  // length of the cascade window in clocks; repetition would unroll too far
  logic [4:0] cas_cnt_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cas_cnt_reg <= 5'h00;
    end else if (ext_ack_cyc) begin
      cas_cnt_reg <= cas_cnt_reg + 5'h01;
    end else begin
      cas_cnt_reg <= 5'h00;
    end
  end
  AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  AST_APB_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_SLVERR: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_ACK_ANS: assert property (cpu_ack && !ext_ack_cyc |=> cpu_ans.vld || ext_ack_cyc)
    else $error("acknowledge not answered");
  AST_ANS_CAUSE: assert property (cpu_ans.vld |-> $past(cpu_ack) || $past(ext_ack_cyc))
    else $error("answer without acknowledge");
  AST_VLD_PULSE: assert property (cpu_ans.vld |=> !cpu_ans.vld)
    else $error("answer valid too long");
  AST_REQ_FALL: assert property (cpu_ack && !ext_ack_cyc |=> !irq_req)
    else $error("request kept after acknowledge");
  AST_REQ_LAT: assert property ($fell(irq_req) |-> !irq_req[*4])
    else $error("request back too soon");
  AST_CAS_LEN: assert property ($fell(ext_ack_cyc) |-> cas_cnt_reg == 5'h0D && cpu_ans.vld)
    else $error("cascade window length wrong");
  AST_CAS_MAX: assert property (cas_cnt_reg <= 5'h0D)
    else $error("cascade window too long");
  AST_ACKOUT_LOW: assert property ($rose(ext_ack_cyc) |=> !ext_irq2_o || !ext_irq3_o)
    else $error("acknowledge output not driven");
  AST_ACKOUT_WIN: assert property (!ext_irq2_o || !ext_irq3_o |-> $past(ext_ack_cyc))
    else $error("acknowledge output outside window");
  AST_OE_CAUSE: assert property ($rose(ext_irq2_oe) || $rose(ext_irq3_oe) |->
    $past(apb_wr) || $past(apb_wr, 2) || $past(apb_wr, 3))
    else $error("pin turned output without write");
  cover property ($fell(ext_ack_cyc));
  cover property (cpu_ans.vld);
  cover property (pslverr);
endmodule : npi_unit_sva

bind npi_unit npi_unit_sva i_sva (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .cpu_ack(cpu_ack),
  .irq_req(irq_req), .cpu_ans(cpu_ans), .ext_irq2_o(ext_irq2_o),
  .ext_irq3_o(ext_irq3_o), .ext_irq2_oe(ext_irq2_oe),
  .ext_irq3_oe(ext_irq3_oe), .ext_ack_cyc(ext_ack_cyc)
);

// file: tb/npi_core_model.sv
// processor core and cascaded slave controller model
`timescale 1ns/1ns
module npi_core_model #(
  parameter logic [7:0] SLV_T = 8'h47 // arbitrary slave type
) (
  input wire logic core_clk, // clock
  input wire logic rst_n, // reset
  input wire logic irq_req, // request
  input wire logic ack_en, // core accepts
  input wire logic [3:0] dly, // acknowledge delay
  input wire logic ack_out0_n, // slave select
  output logic cpu_ack, // acknowledge pulse
  output logic [7:0] slv_type // slave type bus
);
  // ----------------------------------------
  // core and slave
  // ----------------------------------------
  logic [3:0] cnt_reg;
  logic [4:0] gap_reg;
  logic [7:0] junk_reg;
  // unselected slave leaves the bus; toggling exposes early sampling
  assign slv_type = ack_out0_n ? junk_reg : SLV_T;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_ack <= 1'b0;
      cnt_reg <= 4'h0;
      gap_reg <= 5'h00;
      junk_reg <= 8'h5A;
    end else begin
      junk_reg <= ~junk_reg;
      cpu_ack <= 1'b0;
      // core stays busy in its acknowledge sequence
      if (gap_reg != 5'h00) begin
        gap_reg <= gap_reg - 5'h01;
      end else if (ack_en && irq_req) begin
        cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg >= dly) begin
          cpu_ack <= 1'b1;
          cnt_reg <= 4'h0;
          gap_reg <= 5'h14;
        end
      end else begin
        cnt_reg <= 4'h0;
      end
    end
  end
endmodule : npi_core_model

// file: tb/tb_top.sv
// self-checking bench for the nested priority interrupt unit
`timescale 1ns/1ns
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
  $display("ERROR %0t: got %h expected %h", $time, (a), (e)); end end
module tb_top
  import npi_pkg::*;
;
  localparam logic [7:0] SLV_T = 8'h47; // arbitrary
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, serr;
  logic [2:0] tmr_evt = 3'h0;
  logic [1:0] dma_evt = 2'h0;
  logic [3:0] pin_drv = 4'h0;
  logic o2, o3, oe2, oe3, cpu_ack, irq_req, ext_ack_cyc;
  logic [7:0] slv_type;
  npi_ans_s cpu_ans;
  logic ack_en = 1'b0;
  logic [3:0] dly = 4'h0;
  logic [7:0] ans_typ = 8'h00;
  int ans_n = 0;
  int failures = 0;
  int tests_run = 0;
  // pin level: the unit drives in cascade, else the source
  wire pin2 = oe2 ? o2 : pin_drv[2];
  wire pin3 = oe3 ? o3 : pin_drv[3];

  npi_unit i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tmr_evt(tmr_evt), .dma_evt(dma_evt),
    .ext_irq0_i(pin_drv[0]), .ext_irq1_i(pin_drv[1]), .ext_irq2_i(pin2),
    .ext_irq2_o(o2), .ext_irq2_oe(oe2), .ext_irq3_i(pin3), .ext_irq3_o(o3),
    .ext_irq3_oe(oe3), .cpu_ack(cpu_ack), .slv_type(slv_type),
    .irq_req(irq_req), .cpu_ans(cpu_ans), .ext_ack_cyc(ext_ack_cyc)
  );
  npi_core_model #(.SLV_T(SLV_T)) i_core (
    .core_clk(core_clk), .rst_n(rst_n), .irq_req(irq_req), .ack_en(ack_en),
    .dly(dly), .ack_out0_n(pin2), .cpu_ack(cpu_ack), .slv_type(slv_type)
  );

  // ----------------------------------------
  // clock, monitor, tasks
  // ----------------------------------------
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (cpu_ans.vld === 1'b1) begin
      ans_typ <= cpu_ans.typ;
      ans_n <= ans_n + 1;
    end
  end
  task automatic apb(input logic w, input logic [7:0] ix, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) failures++;
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic wr(input logic [7:0] ix, input logic [31:0] d);
    apb(1'b1, ix, d);
  endtask : wr
  task automatic rd(input logic [7:0] ix, input logic [31:0] e);
    apb(1'b0, ix, 32'h0000_0000);
    `CHK(rdat, e)
  endtask : rd
  task automatic end_of_interrupt_command;
    wr(8'h22, 32'h0000_8000);
  endtask : end_of_interrupt_command
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wt
  task automatic take(input logic [7:0] e);
    int n;
    n = ans_n;
    ack_en <= 1'b1;
    repeat (80) if (ans_n == n) @(posedge core_clk);
    ack_en <= 1'b0;
    `CHK(ans_typ, e)
  endtask : take
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    #200000;
    failures++;
    wrap_up();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    wt(12);
    rst_n <= 1'b1;
    wt(1);
    rd(8'h2A, 32'h0000_0007);
    rd(8'h28, 32'h0000_007F);
    rd(8'h20, 32'h0000_0000);
    `CHK(serr, 1'b1)
    `CHK({oe2, oe3, o2, o3}, 4'b0011)
    pin_drv[0] <= 1'b1;
    wt(12);
    `CHK(irq_req, 1'b0)
    rd(8'h2E, 32'h0000_0008);
    wr(8'h28, 32'h0000_0000);
    wt(12);
    `CHK(irq_req, 1'b1)
    take(8'h0C);
    pin_drv[0] <= 1'b0;
    rd(8'h2C, 32'h0000_0008);
    rd(8'h2E, 32'h0000_0000);
    pin_drv[3] <= 1'b1;
    wt(12);
    `CHK(irq_req, 1'b0)
    wr(8'h22, 32'h0000_0003);
    wt(12);
    `CHK(irq_req, 1'b1)
    take(8'h0F);
    pin_drv[3] <= 1'b0;
    end_of_interrupt_command();
    pin_drv[1] <= 1'b1;
    take(8'h0D);
    pin_drv[1] <= 1'b0;
    wt(4);
    pin_drv[1] <= 1'b1;
    wt(12);
    `CHK(irq_req, 1'b0)
    wr(8'h3A, 32'h0000_0044);
    wt(12);
    `CHK(irq_req, 1'b1)
    take(8'h0D);
    end_of_interrupt_command();
    wt(12);
    `CHK(irq_req, 1'b0)
    pin_drv[1] <= 1'b0;
    wr(8'h2A, 32'h0000_0003);
    pin_drv[0] <= 1'b1;
    wt(12);
    `CHK(irq_req, 1'b0)
    dma_evt <= 2'b01;
    wt(1);
    dma_evt <= 2'b00;
    take(8'h0A);
    end_of_interrupt_command();
    wr(8'h2A, 32'h0000_0007);
    take(8'h0C);
    pin_drv[0] <= 1'b0;
    end_of_interrupt_command();
    tmr_evt <= 3'b110;
    wt(1);
    tmr_evt <= 3'b000;
    rd(8'h30, 32'h0000_0006);
    rd(8'h2E, 32'h0000_0001);
    take(8'h12);
    rd(8'h30, 32'h0000_0004);
    rd(8'h2E, 32'h0000_0001);
    tmr_evt <= 3'b001;
    wt(1);
    tmr_evt <= 3'b000;
    wt(12);
    `CHK(irq_req, 1'b0)
    end_of_interrupt_command();
    take(8'h08);
    end_of_interrupt_command();
    take(8'h13);
    rd(8'h2E, 32'h0000_0000);
    end_of_interrupt_command();
    dly <= 4'd9;
    wr(8'h3C, 32'h0000_0015);
    pin_drv[2] <= 1'b1;
    take(8'h0E);
    end_of_interrupt_command();
    take(8'h0E);
    pin_drv[2] <= 1'b0;
    wt(4);
    end_of_interrupt_command();
    wr(8'h3C, 32'h0000_001D);
    dly <= 4'd0;
    dma_evt <= 2'b10;
    wt(1);
    dma_evt <= 2'b00;
    rd(8'h26, 32'h0000_800B);
    rd(8'h2C, 32'h0000_0000);
    rd(8'h24, 32'h0000_800B);
    rd(8'h2C, 32'h0000_0004);
    end_of_interrupt_command();
    wr(8'h38, 32'h0000_0033);
    wt(2);
    `CHK({oe2, o2}, 2'b11)
    pin_drv[0] <= 1'b1;
    take(SLV_T);
    pin_drv[0] <= 1'b0;
    end_of_interrupt_command();
    wt(8);
    wrap_up();
  end
endmodule : tb_top
